// ---- lens_axis_drive_control.sv ----
`timescale 1ns/100ps
`default_nettype none

// Three-stage synchroniser for the panel buttons; a change is taken once stages two and three agree.
module button_sync #(parameter int W = 4) (
	input  wire logic         sys_clk,  // System clock.
	input  wire logic         rst,      // Synchronous reset.
	input  wire logic [W-1:0] raw,      // Asynchronous button levels.
	output logic      [W-1:0] clean_ff  // Debounced levels.
);
	logic [W-1:0] s1_ff;
	logic [W-1:0] s2_ff;
	logic [W-1:0] s3_ff;
	wire  [W-1:0] agree = ~(s2_ff ^ s3_ff);
	wire  [W-1:0] nxt_clean = (agree & s3_ff) | (~agree & clean_ff);

	// Stage one feeds stage two only, so metastability never reaches the agreement test.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s1_ff    <= '0;
			s2_ff    <= '0;
			s3_ff    <= '0;
			clean_ff <= '0;
		end else begin
			s1_ff    <= raw;
			s2_ff    <= s1_ff;
			s3_ff    <= s2_ff;
			clean_ff <= nxt_clean;
		end
	end
endmodule

// One lens axis: rate mode, position mode and manual override.
module lens_axis (
	input  wire logic            sys_clk,  // System clock.
	input  wire logic            rst,      // Synchronous reset.
	input  wire logic            rate_load, // New rate level this cycle.
	input  wire logic            tgt_load, // New position target this cycle.
	input  wire logic [15:0]     level,    // Level carried with either load.
	input  wire logic [15:0]     fb,       // Position feedback of this axis.
	input  wire logic            btn_up,   // Manual positive move.
	input  wire logic            btn_dn,   // Manual negative move.
	output lens_pkg::drive_t     drive_ff  // Motor drive request.
);
	import lens_pkg::*;
	mode_t       mode_ff;
	mode_t       nxt_mode;
	logic [15:0] rate_ff;
	logic [15:0] tgt_ff;
	drive_t      nxt_drive;

	wire btn_any = btn_up | btn_dn;
	wire tgt_new = tgt_load && (level != tgt_ff);
	wire at_tgt  = (fb == tgt_ff);

	// Mode follows the latest rate load or a target that differs from the stored one; a reached target drops back to idle.
	always_comb begin
		nxt_mode = mode_ff;
		case (mode_ff)
			MODE_IDLE:     nxt_mode = MODE_IDLE;
			MODE_RATE:     nxt_mode = MODE_RATE;
			MODE_POSITION: if (at_tgt) nxt_mode = MODE_IDLE; // RULE_05
			default:       nxt_mode = MODE_IDLE;
		endcase
		if (rate_load)
			nxt_mode = MODE_RATE;
		else if (tgt_new)
			nxt_mode = MODE_POSITION; // RULE_05
	end

	// Buttons win over host commands so an installer can always move the lens.
	always_comb begin
		nxt_drive = '0;
		if (btn_any) begin
			nxt_drive.pos = btn_up && !btn_dn; // RULE_10
			nxt_drive.neg = btn_dn && !btn_up; // RULE_10
		end else begin
			case (mode_ff)
				MODE_RATE: begin
					nxt_drive.pos = rate_ff > LEVEL_MID; // RULE_07
					nxt_drive.neg = rate_ff < LEVEL_MID; // RULE_08
				end
				MODE_POSITION: begin
					nxt_drive.pos = fb < tgt_ff; // RULE_05
					nxt_drive.neg = fb > tgt_ff; // RULE_05
				end
				default: nxt_drive = '0;
			endcase
		end
	end

	// Axis state.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			mode_ff  <= MODE_IDLE;
			rate_ff  <= LEVEL_MID; // RULE_06
			tgt_ff   <= '0;
			drive_ff <= '0;
		end else begin
			mode_ff  <= nxt_mode;
			rate_ff  <= rate_load ? level : rate_ff;
			tgt_ff   <= tgt_new ? level : tgt_ff;
			drive_ff <= nxt_drive;
		end
	end

	// Axis checks; a load that lands in the same cycle as a reached target legally keeps the axis busy.
	sequence s_new_target;
		tgt_new && !rate_load;
	endsequence

	sequence s_moving_on;
		mode_ff == MODE_POSITION;
	endsequence

	a_target_load: assert property (@(posedge sys_clk) disable iff (rst) // RULE_05
		s_new_target |=> s_moving_on ##0 (tgt_ff == $past(level)))
		else $error("New target did not start position mode.");
	a_pos_stop: assert property (@(posedge sys_clk) disable iff (rst) // RULE_05
		(mode_ff == MODE_POSITION) && at_tgt && !btn_any && !tgt_new && !rate_load
		|=> drive_ff == 2'b00 ##0 mode_ff != MODE_POSITION)
		else $error("Axis kept moving at its target.");
	a_pos_seek: assert property (@(posedge sys_clk) disable iff (rst) // RULE_05
		(mode_ff == MODE_POSITION) && (fb < tgt_ff) && !btn_any |=> drive_ff.pos && !drive_ff.neg)
		else $error("Axis did not seek a higher target.");
	a_hold_still: assert property (@(posedge sys_clk) disable iff (rst) // RULE_06
		(mode_ff == MODE_RATE) && (rate_ff == LEVEL_MID) && !btn_any |=> drive_ff == 2'b00)
		else $error("Axis moved at mid-scale rate.");
	a_rate_up: assert property (@(posedge sys_clk) disable iff (rst) // RULE_07
		(mode_ff == MODE_RATE) && (rate_ff > LEVEL_MID) && !btn_any |=> drive_ff.pos && !drive_ff.neg)
		else $error("Rate above mid did not move positive.");
	a_rate_down: assert property (@(posedge sys_clk) disable iff (rst) // RULE_08
		(mode_ff == MODE_RATE) && (rate_ff < LEVEL_MID) && !btn_any |=> drive_ff.neg && !drive_ff.pos)
		else $error("Rate below mid did not move negative.");
	a_button_move: assert property (@(posedge sys_clk) disable iff (rst) // RULE_10
		btn_up && !btn_dn |=> drive_ff.pos && !drive_ff.neg)
		else $error("Button did not move the axis.");
endmodule

// Top: host frame decode, node identifier, feedback sampling and the three axes.
module lens_axis_drive_control (
	input  wire logic                 sys_clk,      // System clock, 10 MHz.
	input  wire logic                 rst,          // Synchronous reset, active high.
	input  wire lens_pkg::host_cmd_t  host_cmd,     // Decoded host frame, one-cycle valid.
	input  wire logic [15:0]          focus_pot,    // Sampled focus wiper level.
	input  wire logic [15:0]          zoom_pot,     // Sampled zoom wiper level.
	input  wire logic                 zoom_reverse, // High for lenses with reversed zoom sense.
	input  wire logic [3:0]           button_raw,   // Panel buttons, asynchronous.
	output lens_pkg::reply_t          reply_ff,     // Answer to a poll.
	output logic [15:0]               focus_pos_ff, // Focus position feedback.
	output logic [15:0]               zoom_pos_ff,  // Zoom position feedback.
	output logic [7:0]                network_node_identifier_ff, // Current identifier.
	output logic                      net_led_ff,   // Network indicator.
	output lens_pkg::drive_t          iris_drive,   // Iris motor drive.
	output lens_pkg::drive_t          focus_drive,  // Focus motor drive.
	output lens_pkg::drive_t          zoom_drive    // Zoom motor drive.
);
	import lens_pkg::*;
	logic [BTN_COUNT-1:0] btn;
	reply_t               nxt_reply;

	// Frame decode: nothing below acts on a frame for another node.
	wire addressed  = host_cmd.valid && (host_cmd.node == network_node_identifier_ff); // RULE_01
	wire id_ok      = (host_cmd.level[15:8] == 8'h00) && (host_cmd.level[7:0] >= ID_MIN)
		&& (host_cmd.level[7:0] <= ID_MAX); // RULE_01
	wire set_id     = addressed && (host_cmd.op == OP_SET_ID) && id_ok; // RULE_02
	wire poll       = addressed && (host_cmd.op == OP_POLL);
	wire [7:0]  nxt_id = set_id ? host_cmd.level[7:0] : network_node_identifier_ff;
	wire [15:0] nxt_zoom = zoom_reverse ? (LEVEL_FULL - zoom_pot) : zoom_pot; // RULE_04

	// Poll answer carries the feedback held at the moment of the poll.
	always_comb begin
		nxt_reply.valid = poll; // RULE_01
		nxt_reply.node  = network_node_identifier_ff;
		nxt_reply.focus = focus_pos_ff;
		nxt_reply.zoom  = zoom_pos_ff;
	end

	// Identifier, indicator and feedback registers; the indicator stays lit until reset.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			network_node_identifier_ff <= ID_DEFAULT; // RULE_02
			net_led_ff   <= 1'b0;
			focus_pos_ff <= '0;
			zoom_pos_ff  <= '0;
			reply_ff     <= '0;
		end else begin
			network_node_identifier_ff <= nxt_id; // RULE_02
			net_led_ff   <= net_led_ff | addressed; // RULE_09
			focus_pos_ff <= focus_pot; // RULE_03
			zoom_pos_ff  <= nxt_zoom; // RULE_03
			reply_ff     <= nxt_reply;
		end
	end

	button_sync #(.W(BTN_COUNT)) u_btn (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.raw      (button_raw),
		.clean_ff (btn)
	);

	// Iris has no feedback, so it only ever runs in rate mode.
	lens_axis u_iris (
		.sys_clk   (sys_clk),
		.rst       (rst),
		.rate_load (addressed && (host_cmd.op == OP_IRIS_RATE)),
		.tgt_load  (1'b0),
		.level     (host_cmd.level),
		.fb        (16'h0000),
		.btn_up    (1'b0),
		.btn_dn    (1'b0),
		.drive_ff  (iris_drive)
	);

	lens_axis u_focus (
		.sys_clk   (sys_clk),
		.rst       (rst),
		.rate_load (addressed && (host_cmd.op == OP_FOCUS_RATE)),
		.tgt_load  (addressed && (host_cmd.op == OP_FOCUS_SET)),
		.level     (host_cmd.level),
		.fb        (focus_pos_ff),
		.btn_up    (btn[BTN_FOCUS_IN]),
		.btn_dn    (btn[BTN_FOCUS_OUT]),
		.drive_ff  (focus_drive)
	);

	lens_axis u_zoom (
		.sys_clk   (sys_clk),
		.rst       (rst),
		.rate_load (addressed && (host_cmd.op == OP_ZOOM_RATE)),
		.tgt_load  (addressed && (host_cmd.op == OP_ZOOM_SET)),
		.level     (host_cmd.level),
		.fb        (zoom_pos_ff),
		.btn_up    (btn[BTN_ZOOM_IN]),
		.btn_dn    (btn[BTN_ZOOM_OUT]),
		.drive_ff  (zoom_drive)
	);

	// Identifier, reply, indicator and feedback checks.
	a_id_default: assert property (@(posedge sys_clk) disable iff (rst) // RULE_02
		$fell(rst) |-> network_node_identifier_ff == ID_DEFAULT)
		else $error("Identifier not at default after reset.");
	a_id_accept: assert property (@(posedge sys_clk) disable iff (rst) // RULE_02
		set_id |=> network_node_identifier_ff == $past(host_cmd.level[7:0]))
		else $error("Assigned identifier not taken.");
	a_id_range: assert property (@(posedge sys_clk) disable iff (rst) // RULE_01
		(network_node_identifier_ff >= ID_MIN) && (network_node_identifier_ff <= ID_MAX))
		else $error("Identifier left its legal range.");
	a_reply_cause: assert property (@(posedge sys_clk) disable iff (rst) // RULE_01
		reply_ff.valid |-> $past(poll) && (reply_ff.focus == $past(focus_pos_ff)))
		else $error("Reply without an addressed poll.");
	a_led_cause: assert property (@(posedge sys_clk) disable iff (rst) // RULE_09
		$rose(net_led_ff) |-> $past(addressed))
		else $error("Indicator lit without addressed traffic.");
	a_focus_fb: assert property (@(posedge sys_clk) disable iff (rst) // RULE_03
		!rst |=> focus_pos_ff == $past(focus_pot))
		else $error("Focus feedback does not follow the wiper.");
	a_zoom_sense: assert property (@(posedge sys_clk) disable iff (rst) // RULE_04
		!rst |=> zoom_pos_ff == ($past(zoom_reverse) ? (LEVEL_FULL - $past(zoom_pot)) : $past(zoom_pot)))
		else $error("Zoom feedback sense wrong.");
endmodule
`default_nettype wire

// ---- lens_pkg.sv ----
// How it works
// RULE_01 - Node answers only frames carrying its own identifier, valid range 03 to FE.
// RULE_02 - Identifier resets to 40 and host may assign a new one.
// RULE_03 - Focus and zoom potentiometer wipers are sampled and reported separately.
// RULE_04 - Zoom feedback 0% at wide end, 100% tight; sense may be reversed.
// RULE_05 - New focus or zoom target drives axis until feedback equals target; code ignores a target equal to the stored one.
// RULE_06 - Rate level of 50% holds the axis still.
// RULE_07 - Rate level above 50% moves the axis positive until back at 50%.
// RULE_08 - Rate level below 50% moves the axis negative until back at 50%.
// RULE_09 - Network indicator lights once the host reaches this node's identifier.
// RULE_10 - Local buttons drive focus and zoom in or out manually.
// RULE_11 - Levels are unsigned 16-bit; zero is 0%, full scale 100%, mid-scale 50%.
`default_nettype none
package lens_pkg;
	localparam logic [7:0]  ID_DEFAULT = 8'h40;
	localparam logic [7:0]  ID_MIN     = 8'h03;
	localparam logic [7:0]  ID_MAX     = 8'hFE;
	localparam logic [15:0] LEVEL_MID  = 16'h8000; // RULE_11
	localparam logic [15:0] LEVEL_FULL = 16'hFFFF;

	// Operation codes carried in a host frame.
	localparam logic [2:0] OP_SET_ID     = 3'h0;
	localparam logic [2:0] OP_FOCUS_SET  = 3'h1;
	localparam logic [2:0] OP_ZOOM_SET   = 3'h2;
	localparam logic [2:0] OP_IRIS_RATE  = 3'h3;
	localparam logic [2:0] OP_FOCUS_RATE = 3'h4;
	localparam logic [2:0] OP_ZOOM_RATE  = 3'h5;
	localparam logic [2:0] OP_POLL       = 3'h6;

	// Button bit positions.
	localparam int BTN_FOCUS_IN  = 0;
	localparam int BTN_FOCUS_OUT = 1;
	localparam int BTN_ZOOM_IN   = 2;
	localparam int BTN_ZOOM_OUT  = 3;
	localparam int BTN_COUNT     = 4;

	typedef enum logic [1:0] {MODE_IDLE, MODE_RATE, MODE_POSITION} mode_t;

	typedef struct packed {
		logic        valid;
		logic [7:0]  node;
		logic [2:0]  op;
		logic [15:0] level;
	} host_cmd_t;

	typedef struct packed {
		logic        valid;
		logic [7:0]  node;
		logic [15:0] focus;
		logic [15:0] zoom;
	} reply_t;

	typedef struct packed {
		logic pos;
		logic neg;
	} drive_t;
endpackage
`default_nettype wire

// ---- host_model.sv ----
`timescale 1ns/100ps
`default_nettype none

// Remote control system: issues one decoded frame per call, one cycle long.
module host_model
	import lens_pkg::*;
(
	input  wire logic     sys_clk,  // System clock.
	output var host_cmd_t host_cmd  // Frame to the lens controller.
);
	initial host_cmd = '0;

	// Idle fields are inverted after a frame so that a stale value can never pass for a fresh one.
	task automatic send(input logic [7:0] node, input logic [2:0] op, input logic [15:0] level);
		@(negedge sys_clk);
		host_cmd <= '{1'b1, node, op, level};
		@(negedge sys_clk);
		host_cmd <= '{1'b0, ~node, ~op, ~level};
	endtask
endmodule

`default_nettype wire

// ---- tb_lens_axis_drive_control.sv ----
`timescale 1ns/100ps
`default_nettype none

module tb_lens_axis_drive_control;
	import lens_pkg::*;
	logic        sys_clk = 1'b0;
	logic        rst = 1'b1;
	logic [15:0] focus_pot = 16'h0000;
	logic [15:0] zoom_pot = 16'h0000;
	logic        zoom_reverse = 1'b0;
	logic [3:0]  button_raw = 4'h0;
	host_cmd_t   host_cmd;
	reply_t      reply_ff;
	logic [15:0] focus_pos_ff;
	logic [15:0] zoom_pos_ff;
	logic [7:0]  id_seen;
	logic        net_led_ff;
	drive_t      iris_drive;
	drive_t      focus_drive;
	drive_t      zoom_drive;
	int          errors = 0;
	int          total_checks = 0;
	int          seed = 37163;
	logic [7:0]  nid;
	logic [15:0] lvl;
	logic [15:0] bad [3] = '{16'h0002, 16'h00FF, 16'h0140};
	logic [3:0]  btn [5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3};
	logic [3:0]  bexp [5] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'h0};

	// Free-running 100 ns clock.
	always #50 sys_clk = ~sys_clk;

	host_model i_host (.sys_clk(sys_clk), .host_cmd(host_cmd));

	lens_axis_drive_control i_dut (
		.sys_clk(sys_clk), .rst(rst), .host_cmd(host_cmd), .focus_pot(focus_pot),
		.zoom_pot(zoom_pot), .zoom_reverse(zoom_reverse), .button_raw(button_raw),
		.reply_ff(reply_ff), .focus_pos_ff(focus_pos_ff), .zoom_pos_ff(zoom_pos_ff),
		.network_node_identifier_ff(id_seen), .net_led_ff(net_led_ff),
		.iris_drive(iris_drive), .focus_drive(focus_drive), .zoom_drive(zoom_drive));

	task automatic close_out;
		if (errors == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge sys_clk);
	endtask

	// Reply shows half a cycle after the frame is driven; send returns half a cycle later, while the reply still holds.
	task automatic poll(input logic [7:0] node, input logic exp_v);
		i_host.send(node, OP_POLL, 16'h0000);
		check(reply_ff.valid, exp_v);
		if (exp_v) begin
			check({reply_ff.node, reply_ff.focus}, {node, focus_pot});
			check(reply_ff.zoom, zoom_pot);
		end
	endtask

	// Mid-scale holds; anything above moves positive, anything below negative.
	function automatic logic [1:0] exp_rate(input logic [15:0] l);
		return (l > LEVEL_MID) ? 2'b10 : ((l < LEVEL_MID) ? 2'b01 : 2'b00);
	endfunction

	function automatic logic [1:0] axis_of(input int op);
		return (op == 3) ? iris_drive : ((op == 4) ? focus_drive : zoom_drive);
	endfunction

	// Watchdog: the sequence needs well under a thousand cycles.
	initial begin
		repeat (4000) @(posedge sys_clk);
		errors++;
		close_out();
	end

	initial begin
		tick(20);
		rst = 1'b0;
		check(id_seen, ID_DEFAULT);
		check({net_led_ff, iris_drive, focus_drive, zoom_drive}, 0);
		focus_pot = 16'($random(seed));
		zoom_pot = 16'($random(seed));
		tick(2);
		poll(8'h41, 1'b0);
		check(net_led_ff, 1'b0);
		poll(ID_DEFAULT, 1'b1);
		check(net_led_ff, 1'b1);
		check({focus_pos_ff, zoom_pos_ff}, {focus_pot, zoom_pot});
		// Out-of-range or malformed identifiers must leave the old one in place.
		foreach (bad[i]) begin
			i_host.send(ID_DEFAULT, OP_SET_ID, bad[i]);
			tick(1);
			check(id_seen, ID_DEFAULT);
		end
		nid = ID_MIN + 8'($unsigned($random(seed)) % 252);
		i_host.send(ID_DEFAULT, OP_SET_ID, {8'h00, ID_MIN});
		i_host.send(ID_MIN, OP_SET_ID, {8'h00, ID_MAX});
		i_host.send(ID_MAX, OP_SET_ID, {8'h00, nid});
		tick(1);
		check(id_seen, nid);
		poll(ID_DEFAULT, nid == ID_DEFAULT);
		poll(nid, 1'b1);
		// Focus moves up to its target; zoom, reversed, moves down to its target.
		for (int ax = 0; ax < 2; ax++) begin
			zoom_reverse = ax[0];
			focus_pot = 16'h1000;
			zoom_pot = 16'h0000;
			tick(2);
			check(zoom_pos_ff, ax[0] ? LEVEL_FULL : 16'h0000);
			lvl = 16'h4000 + 16'($random(seed) & 32'h3FFF);
			i_host.send(nid, ax[0] ? OP_ZOOM_SET : OP_FOCUS_SET, lvl);
			tick(2);
			check(ax[0] ? zoom_drive : focus_drive, ax[0] ? 2'b01 : 2'b10);
			focus_pot = lvl;
			zoom_pot = ~lvl;
			tick(4);
			check(ax[0] ? zoom_drive : focus_drive, 2'b00);
		end
		// Each rate axis ends on mid-scale, which must hold it still.
		for (int op = 3; op <= 5; op++) begin
			for (int k = 0; k < 5; k++) begin
				lvl = (k == 0) ? 16'h8001 : (k == 1) ? 16'h7FFF : (k == 4) ? LEVEL_MID : 16'($random(seed));
				i_host.send(nid, op[2:0], lvl);
				tick(2);
				check(axis_of(op), exp_rate(lvl));
			end
		end
		// Panel buttons; both focus buttons at once must cancel.
		foreach (btn[i]) begin
			button_raw = btn[i];
			tick(8);
			check({focus_drive, zoom_drive}, bexp[i]);
			button_raw = 4'h0;
			tick(8);
		end
		// A reset in mid-run drops the assigned identifier, since nothing keeps it over reset.
		rst = 1'b1;
		zoom_reverse = 1'b0;
		tick(2);
		rst = 1'b0;
		check({id_seen, net_led_ff}, {ID_DEFAULT, 1'b0});
		poll(nid, nid == ID_DEFAULT);
		poll(ID_DEFAULT, 1'b1);
		check(net_led_ff, 1'b1);
		close_out();
	end
endmodule

`default_nettype wire
